/* File: shared/spf_pkg.sv */
package spf_pkg;

  // ***************************************************************
  // Word layout
  // ***************************************************************
  localparam int SIGN_BIT  = 31;
  localparam int EXP_HI    = 30;
  localparam int EXP_LO    = 23;
  localparam int FRAC_HI   = 22;
  localparam logic [7:0]  EXP_ZERO = 8'h00;
  localparam logic [7:0]  EXP_INF  = 8'hFF;
  localparam logic [10:0] EXP_BIAS = 11'h07F;
  localparam logic [10:0] EXP_TOP  = 11'h0FF;
  localparam logic [30:0] SAT_MAG  = 31'h7F7FFFFF;

  // ***************************************************************
  // Float status word fields
  // ***************************************************************
  localparam int STAT_OVF  = 0;
  localparam int STAT_UNF  = 1;
  localparam int STAT_ZERO = 2;
  localparam int STAT_NEG  = 3;
  localparam int STAT_RND  = 9;
  localparam logic [31:0] STAT_RESET  = 32'h00000000;
  localparam logic [31:0] RB_RESET    = 32'h00000000;
  localparam logic [31:0] RES_RESET   = 32'h00000000;
  localparam int          NUM_RESULTS = 8;

  // ***************************************************************
  // Operations issued by the host pipeline
  // ***************************************************************
  typedef enum logic [3:0] {
    OP_NOP    = 4'h0,
    OP_LOAD   = 4'h1,
    OP_READ   = 4'h2,
    OP_ADD    = 4'h3,
    OP_SUB    = 4'h4,
    OP_MUL    = 4'h5,
    OP_CMP    = 4'h6,
    OP_SETRND = 4'h7,
    OP_CLRFLG = 4'h8,
    OP_WRRB   = 4'h9,
    OP_RDRB   = 4'hA,
    OP_RDSTF  = 4'hB
  } spf_op_type;

endpackage

/* File: verilog/spf_datapath.sv */
`timescale 1ns/100ps
// Overview of operation
// - Every value is 32 bits: sign bit 31, biased exponent 30:23, fraction 22:0.
// - A sign bit of 0 means positive and 1 means negative.
// - Exponents 1 to 254 are normal numbers with a hidden one and bias 127.
// - An operand with zero exponent and non-zero fraction counts as zero.
// - An all-ones exponent with non-zero fraction is handled as infinity.
// - Negative zero equals positive zero for flags and comparisons.
// - Only truncation and round-to-nearest rounding exist.
// - Round-to-nearest picks the closest value and breaks ties to even.
// - The rounding mode is a bit of the status word set by an instruction.
// - Overflow saturates to the largest magnitude keeping the sign.
// - Latched overflow and underflow flags drive the interrupt expander.
// - Eight 32-bit result registers hold operands and results.
// - A 32-bit status word and a 32-bit repeat-block word are kept too.
// - Only 32-bit float is done here; 64-bit is left to software.
// - The fixed-point core is left untouched by this block.
module spf_datapath (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Instruction from the host pipeline
  input  wire logic        instValid,
  input  wire logic [3:0]  instOp,
  input  wire logic [2:0]  instDst,
  input  wire logic [2:0]  instSrcA,
  input  wire logic [2:0]  instSrcB,
  input  wire logic [31:0] instData,
  // Read-back toward the host
  output logic      [31:0] readData,
  output logic             readValid,
  // Flags toward the peripheral interrupt expander
  output logic             latchedOverflowFlag,
  output logic             latchedUnderflowFlag
);

  // ***************************************************************
  // Helper functions
  // ***************************************************************

  // Denormals flush to +0, NaN collapses to infinity
  function automatic logic [31:0] canon(input logic [31:0] w);
    logic [7:0] ex;
    ex = w[spf_pkg::EXP_HI:spf_pkg::EXP_LO];
    if (ex == spf_pkg::EXP_ZERO) begin
      canon = 32'h00000000;
    end else if (ex == spf_pkg::EXP_INF) begin
      canon = {w[spf_pkg::SIGN_BIT], spf_pkg::EXP_INF, 23'h000000};
    end else begin
      canon = w;
    end
  endfunction

  // Signed ordering key; canonical zero has a clear sign
  function automatic logic signed [32:0] orderKey(input logic [31:0] w);
    logic signed [32:0] mag;
    mag = $signed({2'b00, w[30:0]});
    orderKey = w[spf_pkg::SIGN_BIT] ? -mag : mag;
  endfunction

  // Leading zero count of a 51-bit significand
  function automatic logic [5:0] leadZeros(input logic [50:0] s);
    logic found;
    leadZeros = 6'h00;
    found = 1'b0;
    for (int i = 50; i >= 0; i--) begin
      if (!found && s[i]) begin
        leadZeros = 6'(50 - i);
        found = 1'b1;
      end
    end
  endfunction

  // Normalise, round and pack; returns {ovf, unf, word}
  function automatic logic [33:0] roundPack(
    input logic               sgn,
    input logic signed [10:0] expIn,
    input logic [50:0]        sigIn,
    input logic               nearest
  );
    logic [5:0]         lz;
    logic [50:0]        sig;
    logic [23:0]        man;
    logic               grd;
    logic               stk;
    logic               up;
    logic [24:0]        rnd;
    logic signed [10:0] ex;
    lz  = leadZeros(sigIn);
    sig = sigIn << lz;
    man = sig[50:27];
    grd = sig[26];
    stk = |sig[25:0];
    // Truncation simply drops guard and sticky
    up  = nearest & grd & (stk | man[0]);
    rnd = {1'b0, man} + {24'h000000, up};
    ex  = expIn - $signed({5'h00, lz}) + $signed({10'h000, rnd[24]});
    if (sigIn == 51'h0) begin
      roundPack = {2'b00, 32'h00000000};
    end else if (ex >= $signed(spf_pkg::EXP_TOP)) begin
      // Saturate instead of wrapping into the opposite sign
      roundPack = {2'b10, sgn, spf_pkg::SAT_MAG};
    end else if (ex <= $signed(11'h000)) begin
      roundPack = {2'b01, 32'h00000000};
    end else begin
      roundPack = {2'b00, sgn, ex[7:0],
                   rnd[24] ? rnd[23:1] : rnd[22:0]};
    end
  endfunction

  // ***************************************************************
  // Operand fetch and arithmetic
  // ***************************************************************
  logic [31:0] resultReg_q [spf_pkg::NUM_RESULTS];
  logic [31:0] resultReg_d [spf_pkg::NUM_RESULTS];
  logic [31:0] statusWord_q;
  logic [31:0] statusWord_d;
  logic [31:0] repeatBlock_q;
  logic [31:0] repeatBlock_d;
  logic [31:0] readData_q;
  logic [31:0] readData_d;
  logic        readValid_q;
  logic        readValid_d;

  logic [31:0] opA;
  logic [31:0] opB;
  logic [31:0] opBSub;
  logic        roundNearest;
  logic [33:0] addPack;
  logic [33:0] mulPack;
  logic        cmpLess;
  logic        cmpEqual;

  // Operands read from the result registers
  assign opA          = canon(resultReg_q[instSrcA]);
  assign opB          = canon(resultReg_q[instSrcB]);
  assign roundNearest = statusWord_q[spf_pkg::STAT_RND];

  // Subtraction is addition with the second sign flipped
  assign opBSub = (instOp == spf_pkg::OP_SUB) ?
                  {~opB[spf_pkg::SIGN_BIT], opB[30:0]} : opB;

  // Single precision adder; no wider format exists here
  // Larger magnitude leads, so a non-zero result takes the leader's sign
  always_comb begin : addPath
    logic [31:0]        big;
    logic [31:0]        lesser;
    logic [7:0]         diff;
    logic [50:0]        bigSig;
    logic [50:0]        lessSig;
    logic [50:0]        sum;
    logic               infOp;
    big      = (opA[30:0] >= opBSub[30:0]) ? opA : opBSub;
    lesser   = (opA[30:0] >= opBSub[30:0]) ? opBSub : opA;
    diff     = big[30:23] - lesser[30:23];
    bigSig   = {1'b0, big[30:23] != spf_pkg::EXP_ZERO, big[22:0], 26'h0};
    lessSig  = {1'b0, lesser[30:23] != spf_pkg::EXP_ZERO, lesser[22:0],
                26'h0};
    lessSig  = lessSig >> diff;
    // Effective subtraction when the signs differ
    sum   = (big[31] ^ lesser[31]) ? bigSig - lessSig : bigSig + lessSig;
    infOp = (big[30:23] == spf_pkg::EXP_INF);
    if (infOp) begin
      addPack = {2'b10, big[31], spf_pkg::SAT_MAG};
    end else begin
      addPack = roundPack(big[31],
                          $signed({3'b000, big[30:23]}) + 11'sd1,
                          sum, roundNearest);
    end
  end

  // Single precision multiplier
  always_comb begin : mulPath
    logic [47:0]        prod;
    logic               sgn;
    logic signed [10:0] ex;
    sgn  = opA[spf_pkg::SIGN_BIT] ^ opB[spf_pkg::SIGN_BIT];
    prod = {opA[30:23] != spf_pkg::EXP_ZERO, opA[22:0]} *
           {opB[30:23] != spf_pkg::EXP_ZERO, opB[22:0]};
    ex   = $signed({3'b000, opA[30:23]}) + $signed({3'b000, opB[30:23]})
           - $signed(spf_pkg::EXP_BIAS) + 11'sd1;
    if (opA[30:23] == spf_pkg::EXP_INF || opB[30:23] == spf_pkg::EXP_INF)
    begin
      mulPack = {2'b10, sgn, spf_pkg::SAT_MAG};
    end else if (opA[30:23] == spf_pkg::EXP_ZERO ||
                 opB[30:23] == spf_pkg::EXP_ZERO) begin
      mulPack = {2'b00, 32'h00000000};
    end else begin
      mulPack = roundPack(sgn, ex, {prod, 3'b000}, roundNearest);
    end
  end

  // Comparison on canonical values, so -0 equals +0
  assign cmpLess  = orderKey(opA) < orderKey(opB);
  assign cmpEqual = orderKey(opA) == orderKey(opB);

  // ***************************************************************
  // Register file, status word and read-back
  // ***************************************************************

  // Next state for all architectural state
  always_comb begin : nextState
    logic [33:0] outcome;
    logic        arith;
    outcome       = 34'h0;
    arith         = 1'b0;
    resultReg_d   = resultReg_q;
    statusWord_d  = statusWord_q;
    repeatBlock_d = repeatBlock_q;
    readData_d    = readData_q;
    readValid_d   = 1'b0;
    if (instValid) begin
      unique case (instOp)
        spf_pkg::OP_LOAD: begin
          resultReg_d[instDst] = instData;
        end
        spf_pkg::OP_READ: begin
          readData_d  = resultReg_q[instSrcA];
          readValid_d = 1'b1;
        end
        spf_pkg::OP_ADD, spf_pkg::OP_SUB: begin
          outcome = addPack;
          arith  = 1'b1;
        end
        spf_pkg::OP_MUL: begin
          outcome = mulPack;
          arith  = 1'b1;
        end
        spf_pkg::OP_CMP: begin
          statusWord_d[spf_pkg::STAT_ZERO] = cmpEqual;
          statusWord_d[spf_pkg::STAT_NEG]  = cmpLess;
        end
        spf_pkg::OP_SETRND: begin
          statusWord_d[spf_pkg::STAT_RND] = instData[0];
        end
        spf_pkg::OP_CLRFLG: begin
          statusWord_d[spf_pkg::STAT_OVF] = 1'b0;
          statusWord_d[spf_pkg::STAT_UNF] = 1'b0;
        end
        spf_pkg::OP_WRRB: begin
          repeatBlock_d = instData;
        end
        spf_pkg::OP_RDRB: begin
          readData_d  = repeatBlock_q;
          readValid_d = 1'b1;
        end
        spf_pkg::OP_RDSTF: begin
          readData_d  = statusWord_q;
          readValid_d = 1'b1;
        end
        default: begin
          // No operation; the fixed-point side never sees this block
          readValid_d = 1'b0;
        end
      endcase
    end
    // Results update flags; only new events set the sticky bits
    // Clear and arithmetic are separate opcodes, so they never collide
    if (arith) begin
      resultReg_d[instDst] = outcome[31:0];
      // Zero test ignores the sign, so -0 reads as zero
      statusWord_d[spf_pkg::STAT_ZERO] = (outcome[30:0] == 31'h0);
      statusWord_d[spf_pkg::STAT_NEG]  = outcome[31] &
                                         (outcome[30:0] != 31'h0);
      if (outcome[33]) begin
        statusWord_d[spf_pkg::STAT_OVF] = 1'b1;
      end
      if (outcome[32]) begin
        statusWord_d[spf_pkg::STAT_UNF] = 1'b1;
      end
    end
  end

  // Registers only; synchronous reset
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < spf_pkg::NUM_RESULTS; i++) begin
        resultReg_q[i] <= spf_pkg::RES_RESET;
      end
      statusWord_q  <= spf_pkg::STAT_RESET;
      repeatBlock_q <= spf_pkg::RB_RESET;
      readData_q    <= 32'h00000000;
      readValid_q   <= 1'b0;
    end else begin
      resultReg_q   <= resultReg_d;
      statusWord_q  <= statusWord_d;
      repeatBlock_q <= repeatBlock_d;
      readData_q    <= readData_d;
      readValid_q   <= readValid_d;
    end
  end

  // Latched flags leave straight from the status word
  assign latchedOverflowFlag  = statusWord_q[spf_pkg::STAT_OVF];
  assign latchedUnderflowFlag = statusWord_q[spf_pkg::STAT_UNF];
  assign readData             = readData_q;
  assign readValid            = readValid_q;

endmodule

/* File: verification/spf_host_model.sv */
`timescale 1ns/100ps
// ***************************************************************
// Host pipeline issuing float instructions
// ***************************************************************
module spf_host_model (
  // Clock
  input  wire logic        clock,
  // Instruction toward the datapath
  output logic             instValid = 1'h0,
  output logic [3:0]       instOp    = 4'h0,
  output logic [2:0]       instDst   = 3'h0,
  output logic [2:0]       instSrcA  = 3'h0,
  output logic [2:0]       instSrcB  = 3'h0,
  output logic [31:0]      instData  = 32'h00000000
);
  // One cycle per instruction; no back-pressure exists, so none is awaited
  task automatic issue(input logic [3:0] op, input logic [2:0] d, a, b,
                       input logic [31:0] data);
    @(negedge clock);
    instValid <= 1'h1;
    instOp    <= op;
    instDst   <= d;
    instSrcA  <= a;
    instSrcB  <= b;
    instData  <= data; // 32-bit words only
  endtask
  // Idle: data is scrambled so a stale word never looks valid
  task automatic idle;
    @(negedge clock);
    instValid <= 1'h0;
    instData  <= ~instData;
  endtask
  // Rounding mode changes only through its own instruction
  task automatic set_round(input logic nearest);
    issue(spf_pkg::OP_SETRND, 3'h0, 3'h0, 3'h0, {31'h0, nearest});
  endtask
endmodule

/* File: verification/spf_datapath_monitor.sv */
`timescale 1ns/100ps
// ***************************************************************
// Port checks for the float datapath
// ***************************************************************
module spf_datapath_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Instruction
  input wire logic        instValid,
  input wire logic [3:0]  instOp,
  input wire logic [2:0]  instDst,
  input wire logic [2:0]  instSrcA,
  input wire logic [2:0]  instSrcB,
  input wire logic [31:0] instData,
  // Answers and flags
  input wire logic [31:0] readData,
  input wire logic        readValid,
  input wire logic        latchedOverflowFlag,
  input wire logic        latchedUnderflowFlag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Opcode classes
  logic isRd;
  logic isClr;
  logic isAr;
  assign isRd = instValid && instOp inside {spf_pkg::OP_READ,
                spf_pkg::OP_RDRB, spf_pkg::OP_RDSTF};
  assign isClr = instValid && instOp == spf_pkg::OP_CLRFLG;
  assign isAr = instValid && instOp inside {spf_pkg::OP_ADD,
                spf_pkg::OP_SUB, spf_pkg::OP_MUL};
  // Write followed at once by a read of the same place
  sequence s_load_read;
    instValid && instOp == spf_pkg::OP_LOAD ##1 instValid
      && instOp == spf_pkg::OP_READ && instSrcA == $past(instDst);
  endsequence
  sequence s_rb_read;
    instValid && instOp == spf_pkg::OP_WRRB ##1 instValid
      && instOp == spf_pkg::OP_RDRB;
  endsequence
  sequence s_rnd_read;
    instValid && instOp == spf_pkg::OP_SETRND ##1 instValid
      && instOp == spf_pkg::OP_RDSTF;
  endsequence
  a_read_pulse: assert property (isRd |=> readValid)
    else $error("read not answered");
  a_no_stray: assert property (!isRd |=> !readValid)
    else $error("stray read pulse");
  a_data_hold: assert property (
    !readValid && !$past(rst) |-> $stable(readData))
    else $error("read data moved");
  a_clr_flags: assert property (
    isClr |=> !latchedOverflowFlag && !latchedUnderflowFlag)
    else $error("flags not cleared");
  a_ovf_sticky: assert property (
    latchedOverflowFlag && !isClr |=> latchedOverflowFlag)
    else $error("overflow flag dropped");
  a_unf_sticky: assert property (
    latchedUnderflowFlag && !isClr |=> latchedUnderflowFlag)
    else $error("underflow flag dropped");
  a_ovf_cause: assert property (
    $rose(latchedOverflowFlag) |-> $past(isAr))
    else $error("overflow without arithmetic");
  a_unf_cause: assert property (
    $rose(latchedUnderflowFlag) |-> $past(isAr))
    else $error("underflow without arithmetic");
  a_load_read: assert property (
    s_load_read |=> readData == $past(instData, 2))
    else $error("result register lost value");
  a_rb_read: assert property (
    s_rb_read |=> readData == $past(instData, 2))
    else $error("repeat word lost value");
  a_rnd_bit: assert property (
    s_rnd_read |=> readData[9] == $past(instData[0], 2))
    else $error("rounding bit wrong");
  a_stf_flags: assert property (
    instValid && instOp == spf_pkg::OP_RDSTF
    |=> readData[1:0] == {latchedUnderflowFlag, latchedOverflowFlag})
    else $error("status flags disagree with pins");
endmodule
bind spf_datapath spf_datapath_monitor u_spf_datapath_monitor (.clock, .rst,
  .instValid, .instOp, .instDst, .instSrcA, .instSrcB, .instData, .readData,
  .readValid, .latchedOverflowFlag, .latchedUnderflowFlag);

/* File: verification/spf_datapath_tb.sv */
`timescale 1ns/100ps
module spf_datapath_tb;
  // ***************************************************************
  // Clock, reset and hookup
  // ***************************************************************
  logic        clock = 1'h0;
  logic        rst   = 1'h1;
  logic        instValid, readValid;
  logic [3:0]  instOp;
  logic [2:0]  instDst, instSrcA, instSrcB;
  logic [31:0] instData, readData, r;
  logic        latchedOverflowFlag, latchedUnderflowFlag;
  int          mismatches = 0;
  int          num_checks = 0;
  int          seed       = 21437;
  logic [31:0] a, b;
  initial forever #5 clock = ~clock;
  spf_host_model u_host (.clock, .instValid, .instOp, .instDst, .instSrcA,
    .instSrcB, .instData);
  spf_datapath u_spf_datapath (.clock, .rst, .instValid, .instOp, .instDst,
    .instSrcA, .instSrcB, .instData, .readData, .readValid,
    .latchedOverflowFlag, .latchedUnderflowFlag);
  // Compare and verdict
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Read: answer is sampled on the falling edge after it registers
  task automatic rd(input logic [3:0] op, input logic [2:0] s,
                    output logic [31:0] v);
    u_host.issue(op, 3'h0, s, 3'h0, 32'h00000000);
    u_host.idle();
    chk({31'h0, readValid}, 32'h00000001);
    v = readData;
  endtask
  task automatic ld(input logic [2:0] d, input logic [31:0] v);
    u_host.issue(spf_pkg::OP_LOAD, d, 3'h0, 3'h0, v);
  endtask
  // Reference: denormal to +0, NaN to infinity, -0 to +0
  function automatic logic [31:0] canon(input logic [31:0] x);
    if (x[30:23] == 8'h00) return 32'h00000000;
    if (x[30:23] == 8'hFF) return {x[31], 8'hFF, 23'h000000};
    return x;
  endfunction
  function automatic logic less(input logic [31:0] x, y);
    logic [31:0] p, q;
    p = canon(x);
    q = canon(y);
    if (p == q) return 1'h0;
    if (p[31] != q[31]) return p[31];
    return p[31] ? (p[30:0] > q[30:0]) : (p[30:0] < q[30:0]);
  endfunction
  // One arithmetic vector: mode, operands, result and both flags
  task automatic vec(input logic nr, input logic [3:0] op,
                     input logic [31:0] x, y, e, input logic fo, fu);
    u_host.set_round(nr);
    rd(spf_pkg::OP_RDSTF, 3'h0, r);
    chk({31'h0, r[9]}, {31'h0, nr});
    ld(3'h1, x);
    ld(3'h2, y);
    u_host.issue(op, 3'h3, 3'h1, 3'h2, 32'h00000000);
    rd(spf_pkg::OP_READ, 3'h3, r);
    chk(r, e);
    chk({30'h0, latchedUnderflowFlag, latchedOverflowFlag},
        {30'h0, fu, fo});
    u_host.issue(spf_pkg::OP_CLRFLG, 3'h0, 3'h0, 3'h0, 32'h00000000);
  endtask
  task automatic cmp(input logic [31:0] x, y);
    ld(3'h4, x);
    ld(3'h5, y);
    u_host.issue(spf_pkg::OP_CMP, 3'h0, 3'h4, 3'h5, 32'h00000000);
    rd(spf_pkg::OP_RDSTF, 3'h0, r);
    chk({30'h0, r[3:2]},
        {30'h0, less(x, y), canon(x) == canon(y)});
  endtask
  // ***************************************************************
  // Sequence of scenarios
  // ***************************************************************
  initial begin
    repeat (6) @(negedge clock);
    rst = 1'h0;
    for (int i = 0; i < 8; i++) begin
      rd(spf_pkg::OP_READ, i[2:0], r);
      chk(r, spf_pkg::RES_RESET);
    end
    rd(spf_pkg::OP_RDRB, 3'h0, r);
    chk(r, spf_pkg::RB_RESET);
    rd(spf_pkg::OP_RDSTF, 3'h0, r);
    chk(r, spf_pkg::STAT_RESET);
    for (int i = 0; i < 8; i++) begin
      a = $random(seed);
      ld(i[2:0], a);
      rd(spf_pkg::OP_READ, i[2:0], r);
      chk(r, a);
    end
    a = $random(seed);
    u_host.issue(spf_pkg::OP_WRRB, 3'h0, 3'h0, 3'h0, a);
    rd(spf_pkg::OP_RDRB, 3'h0, r);
    chk(r, a);
    vec(1'h1, spf_pkg::OP_ADD, 32'h3F800000, 32'h3F800000,
        32'h40000000, 1'h0, 1'h0);
    vec(1'h1, spf_pkg::OP_ADD, 32'h3F800000, 32'h34400000,
        32'h3F800002, 1'h0, 1'h0);
    vec(1'h0, spf_pkg::OP_ADD, 32'h3F800000, 32'h34400000,
        32'h3F800001, 1'h0, 1'h0);
    vec(1'h1, spf_pkg::OP_ADD, 32'h3F800001, 32'h33800000,
        32'h3F800002, 1'h0, 1'h0);
    vec(1'h1, spf_pkg::OP_ADD, 32'h3F800000, 32'h33800000,
        32'h3F800000, 1'h0, 1'h0);
    vec(1'h1, spf_pkg::OP_MUL, 32'h7F000000, 32'h40000000,
        32'h7F7FFFFF, 1'h1, 1'h0);
    vec(1'h0, spf_pkg::OP_MUL, 32'h7F000000, 32'hC0000000,
        32'hFF7FFFFF, 1'h1, 1'h0);
    vec(1'h0, spf_pkg::OP_MUL, 32'h00800000, 32'h3F000000,
        32'h00000000, 1'h0, 1'h1);
    vec(1'h1, spf_pkg::OP_ADD, 32'h7FC00000, 32'h3F800000,
        32'h7F7FFFFF, 1'h1, 1'h0);
    vec(1'h1, spf_pkg::OP_ADD, 32'h00000001, 32'h3F800000,
        32'h3F800000, 1'h0, 1'h0);
    vec(1'h1, spf_pkg::OP_SUB, 32'h3F800000, 32'h40000000,
        32'hBF800000, 1'h0, 1'h0);
    cmp(32'h80000000, 32'h00000000);
    cmp(32'h7FC00000, 32'h7F800000);
    cmp(32'h00000001, 32'h80000000);
    cmp(32'hBF800000, 32'h3F800000);
    for (int i = 0; i < 40; i++) begin
      a = $random(seed);
      b = i[0] ? $random(seed) : a ^ 32'h80000000;
      if (a[1:0] == 2'h0) a[30:23] = 8'h00;
      if (a[1:0] == 2'h1) a[30:23] = 8'hFF;
      cmp(a, b);
    end
    close_out();
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    close_out();
  end
endmodule
